// ### common/bl_params.svh
// Timing, reset and field constants of the backlight dimming control
`ifndef BL_PARAMS_SVH
`define BL_PARAMS_SVH
`define BL_CLK_KHZ 125000
`define BL_ABS_GAP_MS 33
`define BL_BOOST_HOLD_MS 25
`define BL_ZERO_CUR_MS 30
`define BL_DUTY_IDLE_MS 20
`define BL_DUTY_FAST_HZ 2000
`define BL_CLK_HZ 125000000
`define BL_SERIAL_MIN_LEN 5
`define BL_SERIAL_MAX_LEN 11
`define BL_ADDR_BRIGHT_HI 8'h00
`define BL_ADDR_BRIGHT_LO 8'h01
`define BL_ADDR_CONFIG 8'h02
`define BL_ADDR_BOOST_MODE 8'h04
`define BL_RST_BRIGHT_HI 8'hFF
`define BL_RST_BRIGHT_LO 3'h0
`define BL_RST_CONFIG 8'hFF
`define BL_RST_BOOST_MODE 8'hFA
`define BL_RST_SERIAL 11'h7FF
`define BL_MODE_MSB 7
`define BL_MODE_LSB 6
`define BL_ABS_EN_BIT 4
`define BL_PEAK_NORMAL_MA 9'h12C
`define BL_PEAK_STEP1_MA 9'h0F0
`define BL_PEAK_STEP2_MA 9'h0C8
`define BL_PEAK_STEP3_MA 9'h0A2
`define BL_HEADROOM_MV 13'h046
`define BL_FULL_SCALE_MA 5'h19
`define BL_FULL_SCALE_ALT_MA 5'h14
`endif

// ### common/bl_types_pkg.sv
// Types shared by the backlight dimming control
package bl_types_pkg;
  typedef enum logic [1:0]
  {
    MODE_SER_I2C_LIN = 2'h0,
    MODE_SER_I2C_LOG = 2'h1,
    MODE_DUTY_I2C_LIN = 2'h2,
    MODE_DUTY_SER_LIN = 2'h3
  } dim_mode_t;
  typedef enum logic [1:0]
  {
    ST_ACTIVE = 2'h0,
    ST_HOLD = 2'h1,
    ST_OFF = 2'h3,
    ST_ZERO = 2'h2
  } lamp_state_t;
  typedef enum logic
  {
    DIV_IDLE = 1'b0,
    DIV_RUN = 1'b1
  } div_state_t;
endpackage

// ### logic/backlight_dimming_control.sv
// Brightness combining, shutdown timing and boost cycle control
//
// Summary of operation
// RULE_01 - Light load: switching gap over 33ms lowers the peak inductor current
// RULE_02 - Peak current steps down through 240mA, 200mA then 162mA
// RULE_03 - Brightness from I2C, duty input or serial codes of 5 to 11 bits
// RULE_04 - Four dimming modes chosen by a two-bit mode field
// RULE_05 - Mode field resets to 11, duty times serial, straps both high
// RULE_06 - Combined modes output the product of the two inputs
// RULE_07 - Mode 10 gives linear duty times I2C brightness
// RULE_08 - Duty held high in mode 10: high byte alone sets output
// RULE_09 - Log mode by writing 01 or strapping clock low, data high
// RULE_10 - Log code N sets current 50uA times 1.00304 power N, zero off
// RULE_11 - Log code is the 11-bit I2C value times the serial value
// RULE_12 - Short serial codes scale up to 11-bit full scale
// RULE_13 - Mode 00 by writing 00 or strapping both I2C pins low
// RULE_14 - Linear serial times I2C uses high byte and 8 serial bits
// RULE_15 - Duty decoder resolves up to 10kHz at 8 bits, faster clock above; code requests it above 2kHz
// RULE_16 - Zero brightness keeps boost regulating 25ms, then boost off
// RULE_17 - Dimming interfaces stay active while enable is high
// RULE_18 - Zero current over 30ms enters the zero-current state
// RULE_19 - Valid non-zero brightness wakes the device and lights the strings
// RULE_20 - Overcurrent ends the switching cycle; resume once current drops
// RULE_21 - Boost tracks the lowest sink voltage toward a 70mV headroom
// RULE_22 - Full scale 25mA per channel, 20mA by factory option
// RULE_23 - Low brightness write takes effect at the next high byte write
// RULE_24 - Peak current stepping runs only while its enable bit is set
// RULE_25 - Products normalised so full times full gives full, truncated
// RULE_26 - Host holds unused serial input low, unused duty input high
`include "bl_params.svh"
module backlight_dimming_control #(
  parameter int ABS_GAP_CYCLES = `BL_ABS_GAP_MS * `BL_CLK_KHZ,
  parameter int BOOST_HOLD_CYCLES = `BL_BOOST_HOLD_MS * `BL_CLK_KHZ,
  parameter int ZERO_CUR_CYCLES = `BL_ZERO_CUR_MS * `BL_CLK_KHZ,
  parameter int DUTY_IDLE_CYCLES = `BL_DUTY_IDLE_MS * `BL_CLK_KHZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable_pin,
  input wire logic duty_dim_input,
  input wire logic scl_strap_pin,
  input wire logic sda_strap_pin,
  input wire logic factory_20ma_pin,
  input wire logic overcurrent_pin,
  input wire logic i2c_wr,
  input wire logic [7:0] i2c_addr,
  input wire logic [7:0] i2c_wdata,
  input wire logic serial_load,
  input wire logic [10:0] serial_bits,
  input wire logic [3:0] serial_len,
  input wire logic cycle_start,
  input wire logic light_load,
  input wire logic [12:0] ch0_headroom_mv,
  input wire logic [12:0] ch1_headroom_mv,
  output logic [10:0] led_code,
  output logic log_mode,
  output logic [1:0] dim_mode,
  output logic leds_on,
  output logic boost_on,
  output logic zero_current,
  output logic [8:0] peak_limit_ma,
  output logic switch_gate,
  output logic vout_raise,
  output logic [4:0] full_scale_ma,
  output logic osc_fast
);
  localparam int TMR_W = 26;

  logic [5:0] sync1;
  logic [5:0] sync2;
  logic en_s;
  logic duty_s;
  logic scl_s;
  logic sda_s;
  logic f20_s;
  logic oc_s;
  logic [1:0] settle;
  logic strap_done;
  logic mode_written;
  logic [7:0] bright_hi;
  logic [2:0] bright_lo_pend;
  logic [2:0] bright_lo;
  logic [7:0] config_reg;
  logic [7:0] boost_mode;
  logic [10:0] serial_val;
  logic [7:0] duty8;
  logic [10:0] next_code;
  bl_types_pkg::lamp_state_t state;
  logic [TMR_W-1:0] zero_tmr;
  logic [TMR_W-1:0] gap_tmr;
  logic [1:0] abs_level;
  logic [12:0] min_headroom;
  bl_types_pkg::dim_mode_t mode;

  generate
    if (ABS_GAP_CYCLES < 1 || BOOST_HOLD_CYCLES < 1 || ZERO_CUR_CYCLES <= BOOST_HOLD_CYCLES
        || ZERO_CUR_CYCLES >= 2 ** TMR_W || ABS_GAP_CYCLES >= 2 ** TMR_W)
    begin : g_bad
      $error("backlight_dimming_control: timing counts out of range");
    end
  endgenerate

  // RULE_12 replicate short code to full scale
  function automatic logic [10:0] scale_to_11(input logic [10:0] v, input logic [3:0] len);
    logic [10:0] r;
    int n;
    r = '0;
    n = int'(len);
    for (int i = 0; i < 11; i++)
      r[i] = v[n - 1 - ((10 - i) % n)];
    return r;
  endfunction

  // RULE_25 divide by full scale, exact for these widths
  function automatic logic [10:0] norm_mul(input logic [10:0] a, input logic [10:0] b,
                                           input logic wide);
    logic [22:0] x;
    logic [22:0] s;
    x = 23'(a) * 23'(b) + 23'h1;
    if (wide)
      s = (x + (x >> 11)) >> 11;
    else
      s = (x + (x >> 8)) >> 8;
    return s[10:0];
  endfunction

  // ***********************************
  // Pin synchronisers
  // ***********************************
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Duty pin idles high
      sync1 <= 6'h02;
      sync2 <= 6'h02;
    end
    else
    begin
      sync1 <= {overcurrent_pin, factory_20ma_pin, sda_strap_pin, scl_strap_pin,
                duty_dim_input, enable_pin};
      sync2 <= sync1;
    end
  end
  assign {oc_s, f20_s, sda_s, scl_s, duty_s, en_s} = sync2;

  duty_cycle_meter #(
    .CNT_W(24),
    .IDLE_CYCLES(DUTY_IDLE_CYCLES)
  ) u_duty (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .level(duty_s),
    .duty(duty8),
    .osc_fast(osc_fast)
  );

  // ***********************************
  // Straps and I2C registers
  // ***********************************
  // Straps are read once the synchronisers have filled after reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settle <= 2'h0;
      strap_done <= 1'b0;
    end
    else if (settle != 2'h3)
      settle <= settle + 2'h1;
    else
      strap_done <= 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      config_reg <= `BL_RST_CONFIG;
      mode_written <= 1'b0;
    end
    // RULE_04 mode field write
    else if (en_s && i2c_wr && i2c_addr == `BL_ADDR_CONFIG)
    begin
      config_reg <= i2c_wdata;
      mode_written <= 1'b1;
    end
    else if (settle == 2'h3 && !strap_done && !mode_written)
    begin
      // RULE_05 both high keeps 11
      if (!scl_s)
        // RULE_09 clock low data high
        // RULE_13 both low
        config_reg[`BL_MODE_MSB:`BL_MODE_LSB] <= sda_s ? 2'h1 : 2'h0;
    end
  end

  // RULE_17 registers accept writes while enabled
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bright_hi <= `BL_RST_BRIGHT_HI;
      bright_lo_pend <= `BL_RST_BRIGHT_LO;
      bright_lo <= `BL_RST_BRIGHT_LO;
      boost_mode <= `BL_RST_BOOST_MODE;
    end
    else if (en_s && i2c_wr)
    begin
      // RULE_23 low byte waits for the high byte
      if (i2c_addr == `BL_ADDR_BRIGHT_LO)
        bright_lo_pend <= i2c_wdata[2:0];
      if (i2c_addr == `BL_ADDR_BRIGHT_HI)
      begin
        bright_hi <= i2c_wdata;
        bright_lo <= bright_lo_pend;
      end
      if (i2c_addr == `BL_ADDR_BOOST_MODE)
        boost_mode <= i2c_wdata;
    end
  end

  // ***********************************
  // Serial brightness value
  // ***********************************
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      serial_val <= `BL_RST_SERIAL;
    else if (en_s && i2c_wr && i2c_addr == `BL_ADDR_CONFIG && i2c_wdata == 8'h00)
      serial_val <= 11'h000;
    // RULE_03 lengths outside 5..11 dropped whole
    else if (en_s && serial_load && serial_len >= 4'(`BL_SERIAL_MIN_LEN)
             && serial_len <= 4'(`BL_SERIAL_MAX_LEN))
      serial_val <= scale_to_11(serial_bits, serial_len);
  end

  // ***********************************
  // Brightness combining
  // ***********************************
  assign mode = bl_types_pkg::dim_mode_t'(config_reg[`BL_MODE_MSB:`BL_MODE_LSB]);

  // RULE_26 unused inputs idle at neutral levels
  always_comb
  begin
    case (mode)
      // RULE_06 duty times serial
      bl_types_pkg::MODE_DUTY_SER_LIN:
        next_code = norm_mul({3'h0, duty8}, {3'h0, serial_val[10:3]}, 1'b0);
      // RULE_07 duty times high byte
      // RULE_08 full duty passes the byte
      bl_types_pkg::MODE_DUTY_I2C_LIN:
        next_code = norm_mul({3'h0, duty8}, {3'h0, bright_hi}, 1'b0);
      // RULE_11 eleven-bit product
      // RULE_10 code drives log current
      bl_types_pkg::MODE_SER_I2C_LOG:
        next_code = norm_mul({bright_hi, bright_lo}, serial_val, 1'b1);
      // RULE_14 top serial byte only
      bl_types_pkg::MODE_SER_I2C_LIN:
        next_code = norm_mul({3'h0, serial_val[10:3]}, {3'h0, bright_hi}, 1'b0);
      default: next_code = 11'h000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      led_code <= 11'h000;
      log_mode <= 1'b0;
      dim_mode <= 2'h3;
    end
    else
    begin
      led_code <= en_s ? next_code : 11'h000;
      log_mode <= mode == bl_types_pkg::MODE_SER_I2C_LOG;
      dim_mode <= config_reg[`BL_MODE_MSB:`BL_MODE_LSB];
    end
  end

  // ***********************************
  // Zero brightness shutdown
  // ***********************************
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= bl_types_pkg::ST_ZERO;
      zero_tmr <= '0;
    end
    else if (!en_s)
    begin
      state <= bl_types_pkg::ST_ZERO;
      zero_tmr <= '0;
    end
    // RULE_19 non-zero wakes
    else if (led_code != 11'h000)
    begin
      state <= bl_types_pkg::ST_ACTIVE;
      zero_tmr <= '0;
    end
    else
    begin
      case (state)
        bl_types_pkg::ST_ACTIVE:
        begin
          state <= bl_types_pkg::ST_HOLD;
          zero_tmr <= TMR_W'(1);
        end
        // RULE_16 boost held 25ms
        bl_types_pkg::ST_HOLD:
        begin
          zero_tmr <= zero_tmr + 1'b1;
          if (zero_tmr == TMR_W'(BOOST_HOLD_CYCLES))
            state <= bl_types_pkg::ST_OFF;
        end
        // RULE_18 zero-current entry
        bl_types_pkg::ST_OFF:
        begin
          zero_tmr <= zero_tmr + 1'b1;
          if (zero_tmr == TMR_W'(ZERO_CUR_CYCLES))
            state <= bl_types_pkg::ST_ZERO;
        end
        bl_types_pkg::ST_ZERO: zero_tmr <= '0;
        default: state <= bl_types_pkg::ST_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      leds_on <= 1'b0;
      boost_on <= 1'b0;
      zero_current <= 1'b0;
    end
    else
    begin
      leds_on <= state == bl_types_pkg::ST_ACTIVE;
      boost_on <= state == bl_types_pkg::ST_ACTIVE || state == bl_types_pkg::ST_HOLD;
      zero_current <= state == bl_types_pkg::ST_ZERO;
    end
  end

  // ***********************************
  // Audible band peak stepping
  // ***********************************
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap_tmr <= '0;
      abs_level <= 2'h0;
    end
    // RULE_24 stepping gated by its enable bit
    else if (!light_load || !boost_mode[`BL_ABS_EN_BIT] || !boost_on)
    begin
      gap_tmr <= '0;
      abs_level <= 2'h0;
    end
    else if (cycle_start)
      gap_tmr <= '0;
    // RULE_01 gap over 33ms steps down
    else if (gap_tmr == TMR_W'(ABS_GAP_CYCLES))
    begin
      gap_tmr <= '0;
      if (abs_level != 2'h3)
        abs_level <= abs_level + 2'h1;
    end
    else
      gap_tmr <= gap_tmr + 1'b1;
  end

  // RULE_02 peak current levels
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      peak_limit_ma <= `BL_PEAK_NORMAL_MA;
    else
    begin
      case (abs_level)
        2'h1: peak_limit_ma <= `BL_PEAK_STEP1_MA;
        2'h2: peak_limit_ma <= `BL_PEAK_STEP2_MA;
        2'h3: peak_limit_ma <= `BL_PEAK_STEP3_MA;
        default: peak_limit_ma <= `BL_PEAK_NORMAL_MA;
      endcase
    end
  end

  // ***********************************
  // Boost cycle, headroom, full scale
  // ***********************************
  // RULE_20 overcurrent ends the cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      switch_gate <= 1'b0;
    else if (cycle_start)
      switch_gate <= boost_on & ~oc_s;
    else if (oc_s || !boost_on)
      switch_gate <= 1'b0;
  end

  assign min_headroom = (ch0_headroom_mv < ch1_headroom_mv) ? ch0_headroom_mv : ch1_headroom_mv;

  // RULE_21 lowest channel against 70mV
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      vout_raise <= 1'b0;
    else if (cycle_start)
      vout_raise <= min_headroom < `BL_HEADROOM_MV;
  end

  // RULE_22 factory full-scale option
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      full_scale_ma <= `BL_FULL_SCALE_MA;
    else
      full_scale_ma <= f20_s ? `BL_FULL_SCALE_ALT_MA : `BL_FULL_SCALE_MA;
  end
endmodule

// ### logic/duty_cycle_meter.sv
// Duty-cycle meter for the synchronised duty dimming input
`include "bl_params.svh"
module duty_cycle_meter #(
  parameter int CNT_W = 24,
  parameter int IDLE_CYCLES = `BL_DUTY_IDLE_MS * `BL_CLK_KHZ,
  parameter int FAST_PERIOD = `BL_CLK_HZ / `BL_DUTY_FAST_HZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic level,
  output logic [7:0] duty,
  output logic osc_fast
);
  logic prev;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] high_cnt;
  logic [CNT_W-1:0] per_cap;
  logic [CNT_W:0] rem;
  logic [7:0] quo;
  logic [2:0] bitn;
  bl_types_pkg::div_state_t state;
  logic rise;
  logic [CNT_W:0] shifted;

  generate
    if (IDLE_CYCLES < 2 || IDLE_CYCLES >= (2 ** CNT_W) - 1)
    begin : g_bad
      $error("duty_cycle_meter: idle count does not fit the counter");
    end
  endgenerate

  assign rise = level & ~prev;
  assign shifted = {rem[CNT_W-1:0], 1'b0};

  // ***********************************
  // Period and high-time measurement
  // ***********************************
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Idle level of the pin, so release gives no false edge
      prev <= 1'b1;
      cnt <= '0;
      high_cnt <= '0;
    end
    else
    begin
      prev <= level;
      if (rise)
      begin
        cnt <= '0;
        // Rising cycle is already high time
        high_cnt <= CNT_W'(1);
      end
      else if (cnt != CNT_W'(IDLE_CYCLES))
      begin
        cnt <= cnt + 1'b1;
        high_cnt <= high_cnt + CNT_W'(level);
      end
    end
  end

  // ***********************************
  // Serial divider, high * 256 / period
  // ***********************************
  // RULE_15 eight-bit duty resolve
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= bl_types_pkg::DIV_IDLE;
      per_cap <= '0;
      rem <= '0;
      quo <= 8'h00;
      bitn <= 3'h0;
      duty <= 8'hFF;
    end
    else
    begin
      case (state)
        bl_types_pkg::DIV_IDLE:
        begin
          if (rise && cnt != '0)
          begin
            per_cap <= cnt + 1'b1;
            if (high_cnt >= cnt)
              duty <= 8'hFF;
            else
            begin
              rem <= {1'b0, high_cnt};
              bitn <= 3'h7;
              state <= bl_types_pkg::DIV_RUN;
            end
          end
          else if (cnt == CNT_W'(IDLE_CYCLES))
            // Static input: full or nothing, no edges to measure
            duty <= level ? 8'hFF : 8'h00;
        end
        bl_types_pkg::DIV_RUN:
        begin
          if (shifted >= {1'b0, per_cap})
          begin
            rem <= shifted - {1'b0, per_cap};
            quo <= {quo[6:0], 1'b1};
          end
          else
          begin
            rem <= shifted;
            quo <= {quo[6:0], 1'b0};
          end
          bitn <= bitn - 1'b1;
          if (bitn == 3'h0)
          begin
            duty <= (shifted >= {1'b0, per_cap}) ? {quo[6:0], 1'b1} : {quo[6:0], 1'b0};
            state <= bl_types_pkg::DIV_IDLE;
          end
        end
        default: state <= bl_types_pkg::DIV_IDLE;
      endcase
    end
  end

  // RULE_15 faster oscillator request
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      osc_fast <= 1'b0;
    else if (state == bl_types_pkg::DIV_RUN && bitn == 3'h7)
      osc_fast <= per_cap < CNT_W'(FAST_PERIOD);
  end
endmodule

// ### verification/backlight_dimming_control_tb.sv
// Self-checking bench for the backlight dimming control
module backlight_dimming_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, enable_pin, scl_strap_pin, sda_strap_pin, factory_20ma_pin;
  logic overcurrent_pin, i2c_wr, cycle_start, light_load, log_mode, leds_on, boost_on;
  logic zero_current, switch_gate, vout_raise, osc_fast, duty_dim_input, serial_load;
  logic [7:0] i2c_addr, i2c_wdata;
  logic [12:0] ch0_headroom_mv, ch1_headroom_mv;
  logic [10:0] serial_bits, led_code;
  logic [3:0] serial_len;
  logic [1:0] dim_mode;
  logic [8:0] peak_limit_ma;
  logic [4:0] full_scale_ma;
  int n_mismatch = 0;
  int tests_run = 0;
  // Short counts keep the shutdown and gap timing within a brief run
  backlight_dimming_control #(.ABS_GAP_CYCLES(50), .BOOST_HOLD_CYCLES(20),
    .ZERO_CUR_CYCLES(40), .DUTY_IDLE_CYCLES(400)) dut (.core_clk, .rst_n, .enable_pin,
    .duty_dim_input, .scl_strap_pin, .sda_strap_pin, .factory_20ma_pin, .overcurrent_pin,
    .i2c_wr, .i2c_addr, .i2c_wdata, .serial_load, .serial_bits, .serial_len, .cycle_start,
    .light_load, .ch0_headroom_mv, .ch1_headroom_mv, .led_code, .log_mode, .dim_mode,
    .leds_on, .boost_on, .zero_current, .peak_limit_ma, .switch_gate, .vout_raise,
    .full_scale_ma, .osc_fast);
  dim_host host (.core_clk, .duty_dim_input, .serial_load, .serial_bits, .serial_len);
  // ****
  // Helpers
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (4) @(negedge core_clk);
  endtask
  task automatic i2c_write(input logic [7:0] a, input logic [7:0] d);
    i2c_addr = a;
    i2c_wdata = d;
    i2c_wr = 1'b1;
    @(negedge core_clk);
    i2c_wr = 1'b0;
    settle();
  endtask
  task automatic pulse_start();
    cycle_start = 1'b1;
    @(negedge core_clk);
    cycle_start = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_default();
    repeat (20) @(negedge core_clk);
    check(dim_mode, 2'h3);
    check(led_code, 16'h00FF);
    check(log_mode, 1'b0);
    check(peak_limit_ma, 9'h12C);
    check(full_scale_ma, 5'h19);
    $display("test default done");
  endtask
  task automatic t_duty_serial();
    host.send_serial(11'h080, 4'h8);
    settle();
    check(led_code, 16'h0080);
    host.send_serial(11'h01B, 4'h5);
    settle();
    check(led_code, 16'h00DE);
    host.send_serial(11'h00F, 4'h4);
    settle();
    check(led_code, 16'h00DE);
    host.set_pwm(100, 200);
    repeat (600) @(negedge core_clk);
    check(led_code, 16'h006F);
    check(osc_fast, 1'b1);
    $display("test duty_serial done");
  endtask
  task automatic t_mode10();
    i2c_write(8'h02, 8'h80);
    check(dim_mode, 2'h2);
    check(led_code, 16'h0080);
    i2c_write(8'h00, 8'h40);
    check(led_code, 16'h0020);
    host.set_pwm(0, 0);
    repeat (600) @(negedge core_clk);
    check(led_code, 16'h0040);
    $display("test mode10 done");
  endtask
  task automatic t_log();
    i2c_write(8'h02, 8'h40);
    check(log_mode, 1'b1);
    check(led_code, 16'h01BD);
    i2c_write(8'h01, 8'h05);
    check(led_code, 16'h01BD);
    i2c_write(8'h00, 8'h80);
    check(led_code, 16'h0380);
    $display("test log done");
  endtask
  task automatic t_mode00();
    // Config written to zero also clears the serial value
    i2c_write(8'h02, 8'h00);
    check(dim_mode, 2'h0);
    check(leds_on, 1'b0);
    check(boost_on, 1'b1);
    repeat (60) @(negedge core_clk);
    check(boost_on, 1'b0);
    check(zero_current, 1'b1);
    host.send_serial(11'h0FF, 4'h8);
    settle();
    check(led_code, 16'h0080);
    check(leds_on, 1'b1);
    host.send_serial(11'h400, 4'hB);
    settle();
    check(led_code, 16'h0040);
    $display("test mode00 done");
  endtask
  task automatic t_abs();
    light_load = 1'b1;
    pulse_start();
    repeat (40) @(negedge core_clk);
    check(peak_limit_ma, 9'h12C);
    repeat (20) @(negedge core_clk);
    check(peak_limit_ma, 9'h0F0);
    repeat (110) @(negedge core_clk);
    check(peak_limit_ma, 9'h0A2);
    i2c_write(8'h04, 8'hEA);
    check(peak_limit_ma, 9'h12C);
    light_load = 1'b0;
    $display("test abs done");
  endtask
  task automatic t_boost();
    pulse_start();
    check(switch_gate, 1'b1);
    overcurrent_pin = 1'b1;
    repeat (5) @(negedge core_clk);
    check(switch_gate, 1'b0);
    overcurrent_pin = 1'b0;
    ch1_headroom_mv = 13'h03C;
    pulse_start();
    check(vout_raise, 1'b1);
    ch1_headroom_mv = 13'h050;
    pulse_start();
    check(vout_raise, 1'b0);
    factory_20ma_pin = 1'b1;
    repeat (5) @(negedge core_clk);
    check(full_scale_ma, 5'h14);
    // Writes while disabled must be refused
    enable_pin = 1'b0;
    settle();
    i2c_write(8'h00, 8'h00);
    check(zero_current, 1'b1);
    enable_pin = 1'b1;
    repeat (6) @(negedge core_clk);
    check(led_code, 16'h0040);
    check(leds_on, 1'b1);
    $display("test boost done");
  endtask
  task automatic strap_reset(input logic sda);
    scl_strap_pin = 1'b0;
    sda_strap_pin = sda;
    rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge core_clk);
  endtask
  task automatic t_strap();
    strap_reset(1'b1);
    check(dim_mode, 2'h1);
    check(log_mode, 1'b1);
    strap_reset(1'b0);
    check(dim_mode, 2'h0);
    check(log_mode, 1'b0);
    $display("test strap done");
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    rst_n = 1'b0;
    enable_pin = 1'b1;
    scl_strap_pin = 1'b1;
    sda_strap_pin = 1'b1;
    factory_20ma_pin = 1'b0;
    overcurrent_pin = 1'b0;
    i2c_wr = 1'b0;
    i2c_addr = 8'h00;
    i2c_wdata = 8'h00;
    cycle_start = 1'b0;
    light_load = 1'b0;
    ch0_headroom_mv = 13'h064;
    ch1_headroom_mv = 13'h064;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    t_default();
    t_duty_serial();
    t_mode10();
    t_log();
    t_mode00();
    t_abs();
    t_boost();
    t_strap();
    print_verdict();
  end
endmodule

// ### verification/bl_dim_monitor.sv
// Port-level checks on the backlight dimming control
module bl_dim_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable_pin,
  input wire logic overcurrent_pin,
  input wire logic cycle_start,
  input wire logic light_load,
  input wire logic [12:0] ch0_headroom_mv,
  input wire logic [12:0] ch1_headroom_mv,
  input wire logic [10:0] led_code,
  input wire logic log_mode,
  input wire logic leds_on,
  input wire logic boost_on,
  input wire logic zero_current,
  input wire logic [8:0] peak_limit_ma,
  input wire logic switch_gate,
  input wire logic vout_raise
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Assertions
  // ****
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  gate_oc_a: assert property (overcurrent_pin [*5] |-> !switch_gate)
    else $error("switch gate high under overcurrent");
  gate_rise_a: assert property ($rose(switch_gate) |-> $past(cycle_start)
    && $past(boost_on))
    else $error("switch gate rose without a cycle start");
  vout_track_a: assert property (cycle_start |=> vout_raise ==
    (($past(ch0_headroom_mv) < 13'h046) || ($past(ch1_headroom_mv) < 13'h046)))
    else $error("output raise does not follow lowest headroom");
  hold_boost_a: assert property ($fell(leds_on) && enable_pin && $past(enable_pin, 4)
    |-> boost_on [*8])
    else $error("boost dropped right after strings went dark");
  zero_dark_a: assert property (zero_current |-> !leds_on && !boost_on)
    else $error("strings or boost on in zero-current state");
  lin_code_a: assert property ((!log_mode) [*4] |-> led_code[10:8] == 3'h0)
    else $error("linear code wider than 8 bits");
  peak_norm_a: assert property ((!light_load) [*3] |-> peak_limit_ma == 9'h12C)
    else $error("peak limit stepped outside light load");
  peak_step_a: assert property ($changed(peak_limit_ma) && peak_limit_ma != 9'h12C
    |-> (peak_limit_ma == 9'h0F0 && $past(peak_limit_ma) == 9'h12C)
    || (peak_limit_ma == 9'h0C8 && $past(peak_limit_ma) == 9'h0F0)
    || (peak_limit_ma == 9'h0A2 && $past(peak_limit_ma) == 9'h0C8))
    else $error("peak limit step out of order");
endmodule
bind backlight_dimming_control bl_dim_monitor u_mon (.core_clk, .rst_n, .enable_pin,
  .overcurrent_pin, .cycle_start, .light_load, .ch0_headroom_mv, .ch1_headroom_mv, .led_code,
  .log_mode, .leds_on, .boost_on, .zero_current, .peak_limit_ma, .switch_gate, .vout_raise);

// ### verification/dim_host.sv
// Host model driving the duty and serial dimming inputs
module dim_host (
  input wire logic core_clk,
  output logic duty_dim_input,
  output logic serial_load,
  output logic [10:0] serial_bits,
  output logic [3:0] serial_len
);
  timeunit 1ns;
  timeprecision 1ps;
  int hi_cyc;
  int per_cyc;
  int cnt;
  // ****
  // Drivers
  // ****
  // idle levels at start
  initial
  begin
    hi_cyc = 0;
    per_cyc = 0;
    cnt = 0;
    duty_dim_input = 1'b1;
    serial_load = 1'b0;
    serial_bits = 11'h000;
    serial_len = 4'h0;
  end
  always @(negedge core_clk)
  begin
    cnt <= (cnt + 1 >= per_cyc) ? 0 : cnt + 1;
    duty_dim_input <= (per_cyc == 0) || (cnt < hi_cyc);
  end
  task automatic set_pwm(input int h, input int p);
    hi_cyc = h;
    per_cyc = p;
  endtask
  task automatic send_serial(input logic [10:0] b, input logic [3:0] n);
    @(negedge core_clk);
    serial_bits = b;
    serial_len = n;
    serial_load = 1'b1;
    @(negedge core_clk);
    serial_load = 1'b0;
    // Stale bits inverted so nothing can live off the old value
    serial_bits = ~b;
  endtask
endmodule
